// >>> cts_pkg.sv
// constants, register map and state encoding for the touch scan sequencer
`default_nettype none
package cts_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CTS_NPAD = 10;
  localparam int CTS_CW   = 16;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] CTS_OFS_CTRL    = 8'h00;
  localparam logic [7:0] CTS_OFS_PERIOD  = 8'h04;
  localparam logic [7:0] CTS_OFS_TIMING  = 8'h08;
  localparam logic [7:0] CTS_OFS_MEASLEN = 8'h0c;
  localparam logic [7:0] CTS_OFS_PADEN   = 8'h10;
  localparam logic [7:0] CTS_OFS_SETA    = 8'h14;
  localparam logic [7:0] CTS_OFS_SETB    = 8'h18;
  localparam logic [7:0] CTS_OFS_STATUS  = 8'h1c;
  localparam logic [7:0] CTS_OFS_TOUCHED = 8'h20;
  localparam logic [1:0] CTS_RGN_THRESH  = 2'h1;
  localparam logic [1:0] CTS_RGN_COUNT   = 2'h2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTS_CTRL_OVR    = 0;
  localparam int CTS_CTRL_BOTH   = 1;
  localparam int CTS_CTRL_START  = 2;
  localparam int CTS_STAT_DONE   = 0;
  localparam int CTS_STAT_BUSY   = 1;
  localparam int CTS_STAT_WAKE   = 2;
  localparam int CTS_TIM_PWR_LSB = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CTS_RST_PERIOD  = 16'h0100;
  localparam logic [7:0]  CTS_RST_BIASDLY = 8'h04;
  localparam logic [7:0]  CTS_RST_PWRDLY  = 8'h04;
  localparam logic [15:0] CTS_RST_MEASLEN = 16'h0200;
  localparam logic [15:0] CTS_RST_THRESH  = 16'h0000;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    CTS_IDLE  = 3'h0,
    CTS_BIAS  = 3'h1,
    CTS_POWER = 3'h2,
    CTS_MEAS  = 3'h3,
    CTS_EVAL  = 3'h4
  } cts_state_t;

endpackage
`default_nettype wire

// >>> cts_scan_fsm.sv
// touch scan sequencer with avalon-mm register slave
//
// Contract
// [RULE_01] with override set, one measurement per software start; timer ignored
// [RULE_02] with override clear, measurements launch periodically from the timer
// [RULE_03] keeps running in system sleep; no sleep gating anywhere
// [RULE_04] timer interval is a programmable count of sequencer clock cycles
// [RULE_05] all timing and counting run on the one sequencer clock
// [RULE_06] bias, then power-up, then start, with programmable delays between
// [RULE_07] power-up and start strobes gated per pad by the enable mask
// [RULE_08] ten independent pulse counters, each final count readable
// [RULE_09] each analog pad returns one pulse per charge/discharge swing
// [RULE_10] every pad counts over the same fixed measurement interval
// [RULE_11] pad touched when its count is strictly below its threshold
// [RULE_12] two 10-bit masks define wake set a and wake set b
// [RULE_13] default mode: wake when any touched pad is in set a
// [RULE_14] both mode: wake only when touched pads exist in both sets
// [RULE_15] per-pad writable thresholds and a pollable done flag
`default_nettype none
module cts_scan_fsm #(
  parameter int NPAD = cts_pkg::CTS_NPAD,
  parameter int CW   = cts_pkg::CTS_CW
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [7:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output var  logic [31:0]     avs_readdata,
  output var  logic            avs_waitrequest,
  input  wire logic [NPAD-1:0] pad_pulse_out,
  output var  logic            sense_bias_enable,
  output var  logic [NPAD-1:0] pad_power_up,
  output var  logic [NPAD-1:0] pad_start,
  output var  logic            wake_irq
);
  import cts_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  cts_state_t      state_reg;
  cts_state_t      state_next;
  logic            ovr_reg;
  logic            both_reg;
  logic [15:0]     period_reg;
  logic [7:0]      bias_dly_reg;
  logic [7:0]      pwr_dly_reg;
  logic [15:0]     meas_len_reg;
  logic [NPAD-1:0] pad_en_reg;
  logic [NPAD-1:0] set_a_reg;
  logic [NPAD-1:0] set_b_reg;
  logic [NPAD-1:0] touched_reg;
  logic [NPAD-1:0] touched_next;
  logic [NPAD-1:0] pulse_prev_reg;
  logic [CW-1:0]   thresh_reg [NPAD];
  logic [CW-1:0]   count_reg  [NPAD];
  logic [15:0]     dly_cnt_reg;
  logic [15:0]     period_cnt_reg;
  logic            sw_pend_reg;
  logic            done_reg;
  logic            launch;
  logic            wake_next;
  logic            wr_go;
  logic            done_clr;
  logic [31:0]     rd_word;
  logic [3:0]      idx;
  logic            pad_ok;

  assign idx    = avs_address[5:2];
  assign pad_ok = (idx < 4'(NPAD));
  assign wr_go  = avs_write && !avs_waitrequest; // write lands on the accept edge
  assign done_clr = wr_go && (avs_address == CTS_OFS_STATUS) &&
                    avs_writedata[CTS_STAT_DONE];

  // ****************************************
  // bus slave
  // ****************************************

  // read data mux
  always_comb begin
    rd_word = 32'h0;
    unique case (avs_address[7:6])
      CTS_RGN_THRESH: if (pad_ok) rd_word = 32'(thresh_reg[idx]); // RULE_15
      CTS_RGN_COUNT:  if (pad_ok) rd_word = 32'(count_reg[idx]); // RULE_08
      default: begin
        case (avs_address)
          CTS_OFS_CTRL:    rd_word = {30'h0, both_reg, ovr_reg};
          CTS_OFS_PERIOD:  rd_word = {16'h0, period_reg};
          CTS_OFS_TIMING:  rd_word = {16'h0, pwr_dly_reg, bias_dly_reg};
          CTS_OFS_MEASLEN: rd_word = {16'h0, meas_len_reg};
          CTS_OFS_PADEN:   rd_word = 32'(pad_en_reg);
          CTS_OFS_SETA:    rd_word = 32'(set_a_reg);
          CTS_OFS_SETB:    rd_word = 32'(set_b_reg);
          CTS_OFS_STATUS:  rd_word = {29'h0, wake_irq, (state_reg != CTS_IDLE), done_reg};
          CTS_OFS_TOUCHED: rd_word = 32'(touched_reg);
          default:         rd_word = 32'h0;
        endcase
      end
    endcase
  end

  // one wait cycle, then a single accept cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_word;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_reg      <= 1'b0;
      both_reg     <= 1'b0;
      period_reg   <= CTS_RST_PERIOD;
      bias_dly_reg <= CTS_RST_BIASDLY;
      pwr_dly_reg  <= CTS_RST_PWRDLY;
      meas_len_reg <= CTS_RST_MEASLEN;
      pad_en_reg   <= '0;
      set_a_reg    <= '0;
      set_b_reg    <= '0;
    end else if (wr_go) begin
      case (avs_address)
        CTS_OFS_CTRL: begin
          ovr_reg  <= avs_writedata[CTS_CTRL_OVR];
          both_reg <= avs_writedata[CTS_CTRL_BOTH];
        end
        CTS_OFS_PERIOD:  period_reg <= avs_writedata[15:0]; // RULE_04
        CTS_OFS_TIMING: begin
          bias_dly_reg <= avs_writedata[7:0];
          pwr_dly_reg  <= avs_writedata[CTS_TIM_PWR_LSB +: 8];
        end
        CTS_OFS_MEASLEN: meas_len_reg <= avs_writedata[15:0];
        CTS_OFS_PADEN:   pad_en_reg <= avs_writedata[NPAD-1:0];
        CTS_OFS_SETA:    set_a_reg <= avs_writedata[NPAD-1:0]; // RULE_12
        CTS_OFS_SETB:    set_b_reg <= avs_writedata[NPAD-1:0]; // RULE_12
        default: ;
      endcase
    end
  end

  // per-pad thresholds
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NPAD; i++) thresh_reg[i] <= CTS_RST_THRESH;
    end else if (wr_go && avs_address[7:6] == CTS_RGN_THRESH && pad_ok) begin
      thresh_reg[idx] <= avs_writedata[CW-1:0]; // RULE_15
    end
  end

  // software start request, held until a launch with override set takes it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_pend_reg <= 1'b0;
    end else if (wr_go && avs_address == CTS_OFS_CTRL && avs_writedata[CTS_CTRL_START]) begin
      sw_pend_reg <= 1'b1; // new request beats the consume
    end else if (launch && ovr_reg) begin
      sw_pend_reg <= 1'b0; // RULE_01
    end
  end

  // ****************************************
  // sequencer
  // ****************************************

  // launch source: software when overridden, else the timer
  assign launch = (state_reg == CTS_IDLE) &&
                  (ovr_reg ? sw_pend_reg : (period_cnt_reg >= period_reg)); // RULE_01 RULE_02

  // sleep timer counts idle cycles, no sleep gating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      period_cnt_reg <= 16'h0;
    end else if (ovr_reg || launch || state_reg != CTS_IDLE) begin
      period_cnt_reg <= 16'h0; // RULE_03 RULE_04
    end else if (period_cnt_reg != 16'hffff) begin
      period_cnt_reg <= period_cnt_reg + 16'h1;
    end
  end

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CTS_IDLE:  if (launch) state_next = CTS_BIAS;
      CTS_BIAS:  if (dly_cnt_reg >= 16'(bias_dly_reg)) state_next = CTS_POWER; // RULE_06
      CTS_POWER: if (dly_cnt_reg >= 16'(pwr_dly_reg)) state_next = CTS_MEAS; // RULE_06
      CTS_MEAS:  if (dly_cnt_reg >= meas_len_reg) state_next = CTS_EVAL; // RULE_10
      CTS_EVAL:  state_next = CTS_IDLE;
      default:   state_next = CTS_IDLE;
    endcase
  end

  // state and step timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= CTS_IDLE;
      dly_cnt_reg <= 16'h0;
    end else begin
      state_reg   <= state_next; // RULE_05
      dly_cnt_reg <= (state_next != state_reg) ? 16'h0 : dly_cnt_reg + 16'h1;
    end
  end

  // analog strobes, registered from the next state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_bias_enable <= 1'b0;
      pad_power_up      <= '0;
      pad_start         <= '0;
    end else begin
      sense_bias_enable <= state_next inside {CTS_BIAS, CTS_POWER, CTS_MEAS}; // RULE_06
      pad_power_up <= (state_next inside {CTS_POWER, CTS_MEAS}) ? pad_en_reg : '0; // RULE_07
      pad_start    <= (state_next == CTS_MEAS) ? pad_en_reg : '0; // RULE_07
    end
  end

  // ****************************************
  // pulse counters
  // ****************************************

  // rising edges counted per pad, saturating, cleared at launch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_prev_reg <= '0;
      for (int i = 0; i < NPAD; i++) count_reg[i] <= '0;
    end else begin
      pulse_prev_reg <= pad_pulse_out; // RULE_09
      for (int i = 0; i < NPAD; i++) begin
        if (launch) begin
          count_reg[i] <= '0;
        end else if (state_reg == CTS_MEAS && pad_start[i] && pad_pulse_out[i] &&
                     !pulse_prev_reg[i] && count_reg[i] != '1) begin
          count_reg[i] <= count_reg[i] + 1'b1; // RULE_08
        end
      end
    end
  end

  // ****************************************
  // evaluation
  // ****************************************

  // touch decision and wake condition
  always_comb begin
    touched_next = '0;
    for (int i = 0; i < NPAD; i++) begin
      touched_next[i] = pad_en_reg[i] && (count_reg[i] < thresh_reg[i]); // RULE_11
    end
    wake_next = both_reg ? (|(touched_next & set_a_reg) && |(touched_next & set_b_reg)) // RULE_14
                         : |(touched_next & set_a_reg); // RULE_13
  end

  // results latched at the end of each measurement
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      touched_reg <= '0;
      wake_irq    <= 1'b0;
      done_reg    <= 1'b0;
    end else if (state_reg == CTS_EVAL) begin
      touched_reg <= touched_next;
      wake_irq    <= wake_next;
      done_reg    <= 1'b1; // RULE_15
    end else if (done_clr) begin
      wake_irq <= 1'b0;
      done_reg <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_launch;
    state_reg == CTS_IDLE ##1 state_reg == CTS_BIAS;
  endsequence
  sequence s_bias_only;
    sense_bias_enable && pad_power_up == '0 && pad_start == '0;
  endsequence

  bus_accept_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus accept timing wrong");
  sw_only_a: assert property (ovr_reg && !sw_pend_reg && state_reg == CTS_IDLE
    |=> state_reg == CTS_IDLE) // RULE_01
    else $error("launch without software request");
  timer_go_a: assert property (!ovr_reg && state_reg == CTS_IDLE &&
    period_cnt_reg >= period_reg |=> state_reg == CTS_BIAS) // RULE_02
    else $error("timer did not launch");
  bias_first_a: assert property (s_launch |-> s_bias_only) // RULE_06
    else $error("bias step not first");
  strobe_mask_a: assert property (((pad_power_up | pad_start) & ~pad_en_reg) == '0) // RULE_07
    else $error("strobe on disabled pad");
  start_power_a: assert property (pad_start != '0 |-> sense_bias_enable &&
    pad_power_up == pad_start) // RULE_06
    else $error("start without power-up");
  meas_end_a: assert property (state_reg == CTS_MEAS && dly_cnt_reg >= meas_len_reg
    |=> state_reg == CTS_EVAL ##1 state_reg == CTS_IDLE) // RULE_10
    else $error("interval end missed");
  touch_cmp_a: assert property (state_reg == CTS_EVAL && pad_en_reg[0] &&
    count_reg[0] < thresh_reg[0] |=> touched_reg[0] && done_reg) // RULE_11
    else $error("pad 0 touch missed");
  wake_a_a: assert property (state_reg == CTS_EVAL && !both_reg &&
    |(touched_next & set_a_reg) |=> wake_irq) // RULE_13
    else $error("set a wake missed");
  wake_both_a: assert property (state_reg == CTS_EVAL && both_reg &&
    (touched_next & set_b_reg) == '0 |=> !wake_irq) // RULE_14
    else $error("wake without set b");

endmodule
`default_nettype wire

// >>> cts_pad_model.sv
// behavioural model of the ten analog pad oscillators
`default_nettype none
module cts_pad_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [9:0] pad_start,
  input  wire logic [9:0] slow_mask,
  output var  logic [9:0] pad_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_reg [10];

  initial pad_pulse_out = 10'h000;

  // a stopped oscillator rests low; slow pads stand for a touched, high-capacitance pad
  always @(posedge clk) begin
    for (int i = 0; i < 10; i++) begin
      if (reset_n !== 1'b1 || pad_start[i] !== 1'b1) begin
        phase_reg[i] <= 3'h0;
        pad_pulse_out[i] <= 1'b0;
      end else if (phase_reg[i] == (slow_mask[i] ? 3'h3 : 3'h0)) begin
        phase_reg[i] <= 3'h0;
        pad_pulse_out[i] <= ~pad_pulse_out[i];
      end else begin
        phase_reg[i] <= phase_reg[i] + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_capacitive_touch_scan_fsm.sv
// self-checking testbench for the touch scan sequencer
`default_nettype none
module tb_capacitive_touch_scan_fsm;
  timeunit 1ns;
  timeprecision 1ps;
  import cts_pkg::*;

  logic        clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic        sense_bias_enable, wake_irq, bias_q;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, cval;
  logic [9:0]  pad_pulse_out, pad_power_up, pad_start, slow_mask, mask;
  int          mismatches, cmp_count, cycles, n_bias, n_pwr, n_meas, rise_at, gap;

  cts_scan_fsm u_cts_scan_fsm (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pad_pulse_out(pad_pulse_out),
    .sense_bias_enable(sense_bias_enable), .pad_power_up(pad_power_up),
    .pad_start(pad_start), .wake_irq(wake_irq));

  cts_pad_model u_cts_pad_model (
    .clk(clk), .reset_n(reset_n), .pad_start(pad_start), .slow_mask(slow_mask),
    .pad_pulse_out(pad_pulse_out));

  // sequencer clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog, strobe phase counters, gating checks and launch spacing
  always @(posedge clk) begin
    cycles <= cycles + 1;
    bias_q <= sense_bias_enable;
    if (sense_bias_enable === 1'b1 && pad_power_up === 10'h000) n_bias <= n_bias + 1;
    if (pad_power_up !== 10'h000 && pad_start === 10'h000) n_pwr <= n_pwr + 1;
    if (pad_start !== 10'h000) n_meas <= n_meas + 1;
    if (pad_power_up !== 10'h000) chk({22'h0, pad_power_up}, {22'h0, mask}, "power");
    if (pad_start !== 10'h000) chk({31'h0, sense_bias_enable}, 32'h1, "bias");
    if (pad_start !== 10'h000) chk({22'h0, pad_start}, {22'h0, mask}, "start");
    if (sense_bias_enable === 1'b1 && bias_q !== 1'b1) begin
      gap <= cycles - rise_at;
      rise_at <= cycles;
    end
    // watchdog last, so nothing in this process follows the verdict
    if (cycles == 20000) begin
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string m);
    cmp_count++;
    if ((got inside {[lo:hi]}) !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s got %0d", $time, m, got);
    end
  endtask

  // avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  // clear done, launch by control write and poll for done
  task automatic run(input logic [31:0] ctrl);
    wr(CTS_OFS_STATUS, 32'h1);
    wr(CTS_OFS_CTRL, ctrl);
    rd = 32'h0;
    while (rd[CTS_STAT_DONE] !== 1'b1) bus(1'b0, CTS_OFS_STATUS, 32'h0);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rdc(CTS_OFS_PERIOD, {16'h0, CTS_RST_PERIOD}, "period rst");
    rdc(CTS_OFS_TIMING, {16'h0, CTS_RST_PWRDLY, CTS_RST_BIASDLY}, "timing rst");
    rdc(CTS_OFS_MEASLEN, {16'h0, CTS_RST_MEASLEN}, "measlen rst");
    rdc({CTS_RGN_THRESH, 6'h24}, 32'h0, "thresh rst");
    rdc(CTS_OFS_STATUS, 32'h0, "status rst");
    wr(CTS_OFS_CTRL, 32'h1);
    wr(8'h3c, 32'hffff_ffff);
    rdc(8'h3c, 32'h0, "unmapped");
    wr(CTS_OFS_PERIOD, 32'h28);
    wr(CTS_OFS_TIMING, 32'h0302);
    wr(CTS_OFS_MEASLEN, 32'h3f);
    wr(CTS_OFS_PADEN, 32'h37f);
    mask = 10'h37f;
    wr(CTS_OFS_SETA, 32'h004);
    wr(CTS_OFS_SETB, 32'h200);
    for (int i = 0; i < 10; i++) wr({CTS_RGN_THRESH, i[3:0], 2'b00}, 32'h14);
    rdc(CTS_OFS_PADEN, 32'h37f, "paden");
    rdc(CTS_OFS_SETB, 32'h200, "setb");
    $display("test reset done");
  endtask

  task automatic t_sw;
    int b, p, m;
    b = n_bias;
    p = n_pwr;
    m = n_meas;
    run(32'h5);
    chk(n_bias - b, 32'd3, "bias len");
    chk(n_pwr - p, 32'd4, "power len");
    chk(n_meas - m, 32'd64, "meas len");
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, {CTS_RGN_COUNT, i[3:0], 2'b00}, 32'h0);
      if (i == 0) cval = rd;
      if (!mask[i]) chk(rd, 32'h0, "idle pad");
      else if (slow_mask[i]) chk_rng(rd, 6, 9, "slow pad");
      else chk_rng(rd, 29, 33, "fast pad");
    end
    rdc(CTS_OFS_TOUCHED, 32'h00c, "touched");
    rdc(CTS_OFS_STATUS, 32'h5, "wake a");
    chk({31'h0, wake_irq}, 32'h1, "irq set");
    wr(CTS_OFS_STATUS, 32'h1);
    repeat (100) @(posedge clk);
    rdc(CTS_OFS_STATUS, 32'h0, "timer off");
    chk({31'h0, wake_irq}, 32'h0, "irq clr");
    $display("test software start done");
  endtask

  task automatic t_thresh;
    wr({CTS_RGN_THRESH, 6'h00}, cval);
    run(32'h5);
    rdc(CTS_OFS_TOUCHED, 32'h00c, "equal");
    wr({CTS_RGN_THRESH, 6'h00}, cval + 32'h1);
    run(32'h5);
    rdc(CTS_OFS_TOUCHED, 32'h00d, "below");
    wr({CTS_RGN_THRESH, 6'h00}, 32'h14);
    $display("test threshold done");
  endtask

  task automatic t_both;
    run(32'h7);
    rdc(CTS_OFS_STATUS, 32'h1, "b empty");
    wr(CTS_OFS_SETB, 32'h008);
    run(32'h7);
    rdc(CTS_OFS_STATUS, 32'h5, "both");
    wr(CTS_OFS_SETA, 32'h001);
    run(32'h5);
    rdc(CTS_OFS_STATUS, 32'h1, "a empty");
    $display("test wake sets done");
  endtask

  task automatic t_timer;
    for (int p = 40; p <= 80; p += 40) begin
      wr(CTS_OFS_STATUS, 32'h1);
      wr(CTS_OFS_PERIOD, p);
      wr(CTS_OFS_CTRL, 32'h0);
      repeat (3) @(posedge sense_bias_enable);
      repeat (2) @(posedge clk);
      chk_rng(gap, p + 71, p + 75, "spacing");
      bus(1'b0, CTS_OFS_STATUS, 32'h0);
      chk({31'h0, rd[CTS_STAT_DONE]}, 32'h1, "auto done");
      chk({31'h0, rd[CTS_STAT_BUSY]}, 32'h1, "auto busy");
    end
    wr(CTS_OFS_CTRL, 32'h1);
    $display("test timer done");
  endtask

  // reset, scenarios, verdict
  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    slow_mask = 10'h00c;
    mask = 10'h000;
    bias_q = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_sw();
    t_thresh();
    t_both();
    t_timer();
    print_verdict();
  end
endmodule
`default_nettype wire
